// ==== pkg/cdud_pkg.sv ====
// Purpose: constants and types for the context descriptor upper decode
// Assumes: descriptor upper half arrives as bits 375:128, index = bit - 128
// Notes: register offsets are byte addresses on a 12-bit apb window
package cdud_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam int PADDR_W = 12;
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_CAPS = 12'h004;
   localparam logic [11:0] REG_LIM_NS = 12'h008;
   localparam logic [11:0] REG_LIM_S = 12'h00c;
   localparam logic [11:0] REG_STATUS = 12'h010;
   localparam logic [11:0] REG_BASE_LO = 12'h014;
   localparam logic [11:0] REG_BASE_HI = 12'h018;
   localparam logic [4:0] MAP_REGION = 5'h01; // paddr[11:7], 0x080..0x0fc
   localparam int MAP_IDX_LSB = 2;
   localparam logic [31:0] CTRL_MASK = 32'h0007_3f7f;
   localparam logic [31:0] CAPS_MASK = 32'h0000_007f;
   localparam logic [31:0] LIM_MASK = 32'h00ff_ffff;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   // ctrl fields
   localparam int CTRL_WORLD_LSB = 0;
   localparam int CTRL_WIDE_BIT = 3;
   localparam int CTRL_SECURE_BIT = 4;
   localparam int CTRL_S1PE_BIT = 5;
   localparam int CTRL_NSSEL_BIT = 6;
   localparam int CTRL_CFG_LSB = 8;
   localparam int CTRL_WDIS_BIT = 11;
   localparam int CTRL_GRAN_LSB = 12;
   localparam int CTRL_IPS_LSB = 16;
   // caps fields
   localparam int CAP_HIER_BIT = 0;
   localparam int CAP_UNPRIV_BIT = 1;
   localparam int CAP_PAGE_HW_ATTR_SUPPORT_BIT = 2;
   localparam int CAP_PART_NS_BIT = 3;
   localparam int CAP_PART_S_BIT = 4;
   localparam int CAP_NSCAP_BIT = 5;
   localparam int CAP_ORIG_REV_BIT = 6;
   // limit fields
   localparam int LIM_PART_LSB = 0;
   localparam int LIM_MG_LSB = 16;
   // ------------------------------------------------------------
   // descriptor layout, offsets relative to bit 128
   // ------------------------------------------------------------
   localparam int DESC_W = 248;
   localparam int D_NS_BIT = 0;
   localparam int D_HIER_BIT = 1;
   localparam int D_UPB_BIT = 2;
   localparam int D_BASE_LSB = 4;
   localparam int D_BASE_W = 48;
   localparam int D_HWU_LSB = 60;
   localparam int D_ATTR_LO_LSB = 64;
   localparam int D_ATTR_HI_LSB = 96;
   localparam int D_AUX_LO_LSB = 128;
   localparam int D_AUX_HI_LSB = 160;
   localparam int D_PART_LSB = 224;
   localparam int D_MG_LSB = 240;
   localparam int ADDR_W = 52;
   localparam int BASE_TOP_W = 4;     // address bits 51:48
   localparam int ALIGN64_W = 6;      // address bits 5:0
   localparam int VPART_W = 5;
   localparam logic [1:0] GRAN_64K = 2'b11;
   localparam logic [2:0] IPS_52 = 3'h6;
   localparam logic [2:0] CFG_NESTED = 3'b111;
   localparam logic [2:0] CFG_S1_ONLY = 3'b101;
   localparam logic [3:0] ATTR_IWT_RW11 = 4'h3;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      WORLD_KERNEL = 3'h0,
      WORLD_SECURE = 3'h1,
      WORLD_HYP = 3'h2,
      WORLD_HYP_HOST = 3'h3,
      WORLD_MONITOR = 3'h4
   } cdud_world_e;
   typedef enum logic [2:0] {
      MEM_DEV_NGNRNE = 3'h0,
      MEM_DEV_NGNRE = 3'h1,
      MEM_DEV_NGRE = 3'h2,
      MEM_DEV_GRE = 3'h3,
      MEM_NORMAL = 3'h4
   } cdud_mem_e;
   // output size code to address width; reserved codes act as the widest
   function automatic logic [5:0] cdud_ips_bits(input logic [2:0] code);
      case (code)
         3'h0: cdud_ips_bits = 6'd32;
         3'h1: cdud_ips_bits = 6'd36;
         3'h2: cdud_ips_bits = 6'd40;
         3'h3: cdud_ips_bits = 6'd42;
         3'h4: cdud_ips_bits = 6'd44;
         3'h5: cdud_ips_bits = 6'd48;
         default: cdud_ips_bits = 6'd52;
      endcase
   endfunction
endpackage

// ==== design/cdud_attr_decode.sv ====
// Purpose: decode one memory attribute byte, folding reserved encodings
// Assumes: purely combinational, registered by the caller
// Notes: output byte is the effective encoding after folding
`timescale 1ns/1ns
`default_nettype none
module cdud_attr_decode
   import cdud_pkg::*;
(
   input wire logic [7:0] attr_i,
   output cdud_mem_e mem_type_o,
   output logic [7:0] eff_o
);
   // ------------------------------------------------------------
   // fold reserved encodings
   // ------------------------------------------------------------
   always_comb begin
      mem_type_o = MEM_NORMAL;
      eff_o = attr_i;
      if (attr_i[7:4] == 4'h0) begin
         // device kind follows bits 3:2 whether or not rw bits are set
         mem_type_o = cdud_mem_e'({1'b0, attr_i[3:2]});
         eff_o = {4'h0, attr_i[3:2], 2'b00};
      end else if (attr_i[3:0] == 4'h0) begin
         // tagged encoding 0xf0 is not given its own meaning here
         eff_o = {attr_i[7:4], ATTR_IWT_RW11};
      end
   end
endmodule
`default_nettype wire

// ==== design/cdud_top.sv ====
// Purpose: decode upper half of a stage 1 context descriptor for the walker
// Assumes: descriptor fetch result and lookups come from logic on mclk_i
// Notes: stream and capability settings are held in apb registers
`timescale 1ns/1ns
`default_nettype none
module cdud_top
   import cdud_pkg::*;
#(
   parameter int MAP_DEPTH = 32
)(
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [PADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // descriptor fetch completion
   input wire logic desc_valid_i,
   input wire logic [DESC_W-1:0] desc_upper_i,
   // decoded descriptor fields
   output logic desc_loaded_o,
   output logic second_base_ns_attr_o,
   output logic second_hier_attr_disable_o,
   output logic second_unpriv_block_o,
   output logic [ADDR_W-1:0] second_table_base_o,
   output logic desc_illegal_o,
   output logic [3:0] hw_use_sel_o,
   output logic [31:0] attr_indirect_low_o,
   output logic [31:0] attr_indirect_high_o,
   output logic [31:0] aux_attr_low_o,
   output logic [31:0] aux_attr_high_o,
   output logic [15:0] partition_id_o,
   output logic partition_id_unknown_o,
   output logic [7:0] monitor_group_o,
   output logic monitor_group_unknown_o,
   // per-access lookup
   input wire logic lookup_valid_i,
   input wire logic [2:0] attr_index_i,
   input wire logic unpriv_access_i,
   input wire logic tlb_hit_i,
   output logic lookup_done_o,
   output logic unpriv_fault_o,
   output logic [2:0] mem_type_o,
   output logic [7:0] attr_byte_o,
   output logic [7:0] aux_byte_o
);
   // ------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------
   if (MAP_DEPTH < 1 || MAP_DEPTH > (1 << VPART_W)) begin : g_bad_depth
      $error("MAP_DEPTH must be 1 to 32");
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] caps;
      logic [31:0] lim_ns;
      logic [31:0] lim_s;
      logic [MAP_DEPTH-1:0][15:0] vmap;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic loaded;
      logic ns_attr;
      logic hier_dis;
      logic unpriv_blk;
      logic [ADDR_W-1:0] base;
      logic illegal;
      logic [3:0] hw_use;
      logic [31:0] attr_lo;
      logic [31:0] attr_hi;
      logic [31:0] aux_lo;
      logic [31:0] aux_hi;
      logic [15:0] part_id;
      logic part_unk;
      logic [7:0] mon_grp;
      logic mon_unk;
      logic lk_done;
      logic lk_fault;
      logic [2:0] lk_type;
      logic [7:0] lk_attr;
      logic [7:0] lk_aux;
   } cdud_state_s;

   cdud_state_s st_r;
   cdud_state_s st_nxt;
   cdud_mem_e dec_type;
   logic [7:0] dec_eff;
   logic [7:0] raw_attr;

   // pick one byte of a pair of indirection words
   function automatic logic [7:0] cdud_sel_byte(input logic [31:0] lo,
                                                 input logic [31:0] hi,
                                                 input logic [2:0] idx);
      logic [63:0] both;
      both = {hi, lo};
      cdud_sel_byte = both[{idx, 3'b000} +: 8];
   endfunction

   // the byte is chosen from the registered words, so a new descriptor
   // never mixes with a lookup already in flight
   assign raw_attr = cdud_sel_byte(st_r.attr_lo, st_r.attr_hi, attr_index_i);

   cdud_attr_decode u_attr (
      .attr_i(raw_attr),
      .mem_type_o(dec_type),
      .eff_o(dec_eff)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic setup;
      logic access;
      logic hit;
      logic [31:0] rd;
      cdud_world_e world;
      logic hi_world;
      logic secure;
      logic avail;
      logic use_s_lim;
      logic [15:0] pid;
      logic [7:0] mg;
      logic [15:0] plim;
      logic [7:0] mlim;
      logic [2:0] cfg;
      logic [ADDR_W-1:0] base;
      logic [VPART_W-1:0] vid;
      logic [4:0] widx;
      setup = 1'b0;
      access = 1'b0;
      hit = 1'b0;
      rd = RESET_WORD;
      world = cdud_world_e'(st_r.ctrl[CTRL_WORLD_LSB +: 3]);
      hi_world = 1'b0;
      secure = 1'b0;
      avail = 1'b0;
      use_s_lim = 1'b0;
      pid = 16'h0000;
      mg = 8'h00;
      plim = 16'h0000;
      mlim = 8'h00;
      cfg = 3'h0;
      base = '0;
      vid = '0;
      widx = 5'h00;
      st_nxt = st_r;

      // apb: answer is prepared in setup, transfer ends in first access
      setup = psel_i & ~penable_i;
      access = psel_i & penable_i & st_r.pready;
      widx = paddr_i[MAP_IDX_LSB +: 5];
      hit = 1'b1;
      case (paddr_i)
         REG_CTRL: rd = st_r.ctrl;
         REG_CAPS: rd = st_r.caps;
         REG_LIM_NS: rd = st_r.lim_ns;
         REG_LIM_S: rd = st_r.lim_s;
         REG_STATUS: rd = {28'h0, st_r.mon_unk, st_r.part_unk,
                           st_r.loaded, st_r.illegal};
         REG_BASE_LO: rd = st_r.base[31:0];
         REG_BASE_HI: rd = {12'h000, st_r.base[ADDR_W-1:32]};
         default: begin
            if (paddr_i[11:7] == MAP_REGION && int'(widx) < MAP_DEPTH) begin
               rd = {16'h0000, st_r.vmap[widx]};
            end else begin
               hit = 1'b0;
            end
         end
      endcase
      st_nxt.pready = setup;
      if (setup) begin
         st_nxt.prdata = hit ? rd : RESET_WORD;
         st_nxt.pslverr = ~hit;
      end
      // writes land only at the completing access edge
      if (access && pwrite_i && hit) begin
         case (paddr_i)
            REG_CTRL: st_nxt.ctrl = pwdata_i & CTRL_MASK;
            REG_CAPS: st_nxt.caps = pwdata_i & CAPS_MASK;
            REG_LIM_NS: st_nxt.lim_ns = pwdata_i & LIM_MASK;
            REG_LIM_S: st_nxt.lim_s = pwdata_i & LIM_MASK;
            REG_STATUS, REG_BASE_LO, REG_BASE_HI: ;
            default: st_nxt.vmap[widx] = pwdata_i[15:0];
         endcase
      end

      // descriptor decode, only when a fetch completes
      hi_world = (world == WORLD_HYP) || (world == WORLD_MONITOR);
      secure = st_r.ctrl[CTRL_SECURE_BIT];
      cfg = st_r.ctrl[CTRL_CFG_LSB +: 3];
      if (desc_valid_i) begin
         st_nxt.loaded = 1'b1;
         // one means non-secure fetch of the starting-level table
         st_nxt.ns_attr = desc_upper_i[D_NS_BIT] & ~hi_world;
         // unsupported feature ignores the bit, so it also reads zero
         st_nxt.hier_dis = desc_upper_i[D_HIER_BIT] & ~hi_world
                           & st_r.caps[CAP_HIER_BIT];
         st_nxt.unpriv_blk = desc_upper_i[D_UPB_BIT]
                           & st_r.caps[CAP_UNPRIV_BIT]
                           & st_r.ctrl[CTRL_WIDE_BIT]
                           & ((world == WORLD_KERNEL) || (world == WORLD_SECURE)
                              || (world == WORLD_HYP_HOST));
         base = {desc_upper_i[D_BASE_LSB +: D_BASE_W], 4'h0};
         if (st_r.caps[CAP_ORIG_REV_BIT]) begin
            base[ADDR_W-1 -: BASE_TOP_W] = '0;
         end
         if (st_r.ctrl[CTRL_GRAN_LSB +: 2] == GRAN_64K
             && st_r.ctrl[CTRL_IPS_LSB +: 3] >= IPS_52) begin
            base[ALIGN64_W-1:0] = '0;
         end
         if (hi_world) begin
            base = '0;
         end
         st_nxt.base = base;
         // legality is only judged when the base is in use
         st_nxt.illegal = ~hi_world & ~st_r.ctrl[CTRL_WDIS_BIT]
            & (((base >> cdud_ips_bits(st_r.ctrl[CTRL_IPS_LSB +: 3])) != '0)
               || (st_r.ctrl[CTRL_GRAN_LSB +: 2] != GRAN_64K
                   && base[ADDR_W-1 -: BASE_TOP_W] != '0));
         st_nxt.hw_use = desc_upper_i[D_HWU_LSB +: 4]
                       & {4{st_r.caps[CAP_PAGE_HW_ATTR_SUPPORT_BIT] & st_nxt.hier_dis}};
         st_nxt.attr_lo = desc_upper_i[D_ATTR_LO_LSB +: 32];
         st_nxt.attr_hi = desc_upper_i[D_ATTR_HI_LSB +: 32];
         // auxiliary words carry no meaning here, they are passed through unchanged
         st_nxt.aux_lo = desc_upper_i[D_AUX_LO_LSB +: 32];
         st_nxt.aux_hi = desc_upper_i[D_AUX_HI_LSB +: 32];

         // partition and monitor group tags
         avail = (secure ? st_r.caps[CAP_PART_S_BIT] : st_r.caps[CAP_PART_NS_BIT])
               & st_r.ctrl[CTRL_S1PE_BIT];
         use_s_lim = secure & ~(st_r.caps[CAP_NSCAP_BIT]
                               & st_r.ctrl[CTRL_NSSEL_BIT]);
         plim = use_s_lim ? st_r.lim_s[LIM_PART_LSB +: 16]
                          : st_r.lim_ns[LIM_PART_LSB +: 16];
         mlim = use_s_lim ? st_r.lim_s[LIM_MG_LSB +: 8]
                          : st_r.lim_ns[LIM_MG_LSB +: 8];
         pid = desc_upper_i[D_PART_LSB +: 16];
         mg = desc_upper_i[D_MG_LSB +: 8];
         vid = pid[VPART_W-1:0];
         st_nxt.part_id = 16'h0000;
         st_nxt.part_unk = 1'b0;
         st_nxt.mon_grp = 8'h00;
         st_nxt.mon_unk = 1'b0;
         if (avail) begin
            if (cfg == CFG_NESTED) begin
               // upper bits of the field are ignored in this mode
               if (int'(vid) < MAP_DEPTH) begin
                  st_nxt.part_id = st_r.vmap[vid];
               end else begin
                  st_nxt.part_unk = 1'b1;
               end
            end else if (cfg == CFG_S1_ONLY) begin
               if (pid > plim) begin
                  st_nxt.part_unk = 1'b1;
               end else begin
                  st_nxt.part_id = pid;
               end
            end
            if (mg > mlim) begin
               st_nxt.mon_unk = 1'b1;
            end else begin
               st_nxt.mon_grp = mg;
            end
         end
      end

      // lookup: fixed one-cycle answer; tlb_hit_i is deliberately unused so
      // fault timing cannot reveal whether the address was cached
      st_nxt.lk_done = lookup_valid_i;
      if (lookup_valid_i) begin
         // block bit is served from this register, the tlb copy must be
         // invalidated by software when a descriptor changes it
         st_nxt.lk_fault = unpriv_access_i & st_r.unpriv_blk;
         st_nxt.lk_type = dec_type;
         st_nxt.lk_attr = dec_eff;
         st_nxt.lk_aux = cdud_sel_byte(st_r.aux_lo, st_r.aux_hi,
                                       attr_index_i);
      end else begin
         st_nxt.lk_fault = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign prdata_o = st_r.prdata;
   assign pready_o = st_r.pready;
   assign pslverr_o = st_r.pslverr;
   assign desc_loaded_o = st_r.loaded;
   assign second_base_ns_attr_o = st_r.ns_attr;
   assign second_hier_attr_disable_o = st_r.hier_dis;
   assign second_unpriv_block_o = st_r.unpriv_blk;
   assign second_table_base_o = st_r.base;
   assign desc_illegal_o = st_r.illegal;
   assign hw_use_sel_o = st_r.hw_use;
   assign attr_indirect_low_o = st_r.attr_lo;
   assign attr_indirect_high_o = st_r.attr_hi;
   assign aux_attr_low_o = st_r.aux_lo;
   assign aux_attr_high_o = st_r.aux_hi;
   assign partition_id_o = st_r.part_id;
   assign partition_id_unknown_o = st_r.part_unk;
   assign monitor_group_o = st_r.mon_grp;
   assign monitor_group_unknown_o = st_r.mon_unk;
   assign lookup_done_o = st_r.lk_done;
   assign unpriv_fault_o = st_r.lk_fault;
   assign mem_type_o = st_r.lk_type;
   assign attr_byte_o = st_r.lk_attr;
   assign aux_byte_o = st_r.lk_aux;
endmodule
`default_nettype wire

// ==== tb/cdud_desc_mem.sv ====
// Purpose: memory of software-written descriptor images answering fetches
// Assumes: one fetch at a time, answer delay chosen per fetch
// Notes: data lines toggle while no answer stands
`timescale 1ns/1ns
`default_nettype none
module cdud_desc_mem
   import cdud_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic fetch_i,
   input wire logic [3:0] lat_i,
   output logic desc_valid_o,
   output logic [DESC_W-1:0] desc_o
);
   logic [DESC_W-1:0] store_r; // image written by the bench, aux words pass through
   logic [4:0] cnt_r;
   // released lines flip every cycle so stale data never passes as valid
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_r <= 5'h00;
         desc_valid_o <= 1'b0;
         desc_o <= '0;
      end else begin
         desc_valid_o <= 1'b0;
         desc_o <= ~desc_o;
         if (fetch_i) cnt_r <= {1'b0, lat_i} + 5'h01;
         else if (cnt_r != 5'h00) cnt_r <= cnt_r - 5'h01;
         if (cnt_r == 5'h01) begin
            desc_valid_o <= 1'b1;
            desc_o <= store_r;
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb/cdud_monitor.sv ====
// Purpose: port relations of the descriptor decode
// Assumes: bound to cdud_top
// Notes: one clock domain
`timescale 1ns/1ns
`default_nettype none
module cdud_monitor
   import cdud_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic desc_valid_i,
   input wire logic lookup_valid_i,
   input wire logic [2:0] attr_index_i,
   input wire logic lookup_done_o,
   input wire logic unpriv_fault_o,
   input wire logic second_hier_attr_disable_o,
   input wire logic [ADDR_W-1:0] second_table_base_o,
   input wire logic [3:0] hw_use_sel_o,
   input wire logic [31:0] aux_attr_low_o,
   input wire logic [31:0] aux_attr_high_o,
   input wire logic [7:0] aux_byte_o,
   input wire logic [15:0] partition_id_o,
   input wire logic partition_id_unknown_o,
   input wire logic desc_loaded_o
);
   // --------
   // properties
   // --------
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!reset_n_i);
   logic [7:0] aux_sel;
   // aux byte picked from the words held before the lookup edge
   assign aux_sel = 8'({aux_attr_high_o, aux_attr_low_o} >> {attr_index_i, 3'h0});
   sequence s_req;
      lookup_valid_i;
   endsequence
   sequence s_ans;
      lookup_done_o;
   endsequence
   property p_done;
      s_req |=> s_ans;
   endproperty
   property p_lone;
      s_ans |-> $past(lookup_valid_i);
   endproperty
   property p_fault;
      unpriv_fault_o |-> lookup_done_o;
   endproperty
   property p_hold;
      !desc_valid_i |=> $stable(second_table_base_o);
   endproperty
   property p_align;
      second_table_base_o[3:0] == 4'h0;
   endproperty
   property p_hwu;
      (hw_use_sel_o != 4'h0) |-> second_hier_attr_disable_o;
   endproperty
   property p_aux;
      s_req |=> (aux_byte_o == $past(aux_sel));
   endproperty
   property p_pid;
      partition_id_unknown_o |-> (partition_id_o == 16'h0000);
   endproperty
   property p_load;
      desc_valid_i |=> desc_loaded_o;
   endproperty
   a_done: assert property (p_done) else $error("lookup unanswered");
   a_lone: assert property (p_lone) else $error("answer without lookup");
   a_fault: assert property (p_fault) else $error("fault outside answer");
   a_hold: assert property (p_hold) else $error("base moved without fetch");
   a_align: assert property (p_align) else $error("base low bits set");
   a_hwu: assert property (p_hwu) else $error("hw use without hier disable");
   a_aux: assert property (p_aux) else $error("aux byte wrong");
   a_pid: assert property (p_pid) else $error("unknown id not zero");
   a_load: assert property (p_load) else $error("loaded flag missing");
endmodule
`default_nettype wire

// ==== tb/cdud_top_tb_top.sv ====
// Purpose: self-checking bench for the descriptor upper decode
// Assumes: apb master tasks and a descriptor memory model
// Notes: one image decoded under several stream settings
`timescale 1ns/1ns
`default_nettype none
module cdud_top_tb_top;
   import cdud_pkg::*;
   localparam logic [DESC_W-1:0] DESC = {8'h11, 16'h0100, 32'h0, 32'h8765_4321, 32'h0,
      32'h44ff_0a00, 32'hf005_0c50, 4'ha, 8'h00, 48'hfedc_ba98_7653, 4'h7};
   localparam logic [7:0] EFF [8] = '{8'h53, 8'h0c, 8'h04, 8'hf3, 8'h00, 8'h08, 8'hff, 8'h44};
   localparam logic [2:0] MT [8] = '{3'h4, 3'h3, 3'h1, 3'h4, 3'h0, 3'h2, 3'h4, 3'h4};
   localparam logic [51:0] B64 = 52'hf_edcb_a987_6500;
   logic mclk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, fetch = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, prdata_o, q;
   logic pready_o, pslverr_o, e, desc_valid_i, desc_loaded_o;
   logic lookup_valid_i = 1'b0, unpriv_access_i = 1'b0, tlb_hit_i = 1'b0;
   logic [2:0] attr_index_i = 3'h0, mem_type_o;
   logic [3:0] lat = 4'h0, hw_use_sel_o;
   logic [DESC_W-1:0] desc_upper_i;
   logic second_base_ns_attr_o, second_hier_attr_disable_o, second_unpriv_block_o;
   logic desc_illegal_o, partition_id_unknown_o, monitor_group_unknown_o;
   logic lookup_done_o, unpriv_fault_o;
   logic [ADDR_W-1:0] second_table_base_o;
   logic [31:0] attr_indirect_low_o, attr_indirect_high_o, aux_attr_low_o, aux_attr_high_o;
   logic [15:0] partition_id_o;
   logic [7:0] monitor_group_o, attr_byte_o, aux_byte_o;
   int errors = 0, checks = 0, tn = 0;
   cdud_desc_mem mem (.mclk_i, .reset_n_i, .fetch_i(fetch), .lat_i(lat),
      .desc_valid_o(desc_valid_i), .desc_o(desc_upper_i));
   cdud_top dut (.mclk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .desc_valid_i, .desc_upper_i, .desc_loaded_o,
      .second_base_ns_attr_o, .second_hier_attr_disable_o, .second_unpriv_block_o,
      .second_table_base_o, .desc_illegal_o, .hw_use_sel_o, .attr_indirect_low_o,
      .attr_indirect_high_o, .aux_attr_low_o, .aux_attr_high_o, .partition_id_o,
      .partition_id_unknown_o, .monitor_group_o, .monitor_group_unknown_o, .lookup_valid_i,
      .attr_index_i, .unpriv_access_i, .tlb_hit_i, .lookup_done_o, .unpriv_fault_o,
      .mem_type_o, .attr_byte_o, .aux_byte_o);
   // --------
   // tasks
   // --------
   initial begin
      forever #50 mclk_i = ~mclk_i;
   end
   task automatic chk(input string n, input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %0h seen %0h", n, exp, got);
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // a wait that used up its bound ends the run
   task automatic tmo(input logic ok);
      if (ok !== 1'b1) begin
         errors++;
         final_report();
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge mclk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 40);
      tmo(pready_o);
      q = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic look(input logic [2:0] i, input logic u, input logic h);
      @(posedge mclk_i);
      lookup_valid_i <= 1'b1;
      attr_index_i <= i;
      unpriv_access_i <= u;
      tlb_hit_i <= h;
      @(posedge mclk_i);
      lookup_valid_i <= 1'b0;
      #1;
      chk("done", lookup_done_o, 1'b1);
   endtask
   // f holds ns, hier, block, illegal, group unknown
   task automatic dec(input logic [31:0] c, input logic [3:0] l, input logic [4:0] f,
      input logic [51:0] b, input logic [15:0] p, input logic [7:0] m);
      int n;
      n = 0;
      apb(1'b1, REG_CTRL, c);
      @(posedge mclk_i);
      fetch <= 1'b1;
      lat <= l;
      @(posedge mclk_i);
      fetch <= 1'b0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (desc_valid_i !== 1'b1 && n < 40);
      tmo(desc_valid_i);
      #1;
      chk("ns_attr", second_base_ns_attr_o, f[4]);
      chk("hier_dis", second_hier_attr_disable_o, f[3]);
      chk("unpriv_blk", second_unpriv_block_o, f[2]);
      chk("illegal", desc_illegal_o, f[1]);
      chk("mg_unknown", monitor_group_unknown_o, f[0]);
      chk("base", second_table_base_o, b);
      chk("hw_use", hw_use_sel_o, f[3] ? 4'ha : 4'h0);
      chk("part_id", partition_id_o, p);
      chk("mon_grp", monitor_group_o, m);
      chk("attr_w", {attr_indirect_high_o, attr_indirect_low_o}, 64'h44ff_0a00_f005_0c50);
      chk("aux_w", {aux_attr_high_o, aux_attr_low_o}, 64'h8765_4321_0000_0000);
      look(3'h7, 1'b1, l[0]);
      chk("fault", unpriv_fault_o, f[2]);
      tn++;
      $display("decode test %0d done", tn);
   endtask
   // --------
   // sequence
   // --------
   initial begin
      repeat (16) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      apb(1'b0, REG_CAPS, 32'h0);
      chk("caps_rst", q, 32'h0);
      apb(1'b1, 12'h040, 32'hffff_ffff);
      chk("unmap_err", e, 1'b1);
      apb(1'b0, 12'h040, 32'h0);
      chk("unmap_rd", q, 32'h0);
      apb(1'b1, REG_CAPS, 32'h3f);
      apb(1'b0, REG_CAPS, 32'h0);
      chk("caps", q, 32'h3f);
      $display("register test done");
      apb(1'b1, REG_LIM_NS, 32'h0010_0100);
      apb(1'b1, REG_LIM_S, 32'h0020_0100);
      apb(1'b1, 12'h080, 32'h0000_0007);
      mem.store_r = DESC;
      dec(32'h0006_3528, 4'h0, 5'b11101, B64, 16'h0100, 8'h00);
      for (int i = 0; i < 8; i++) begin
         look(i[2:0], i[0], i[1]);
         chk("fault_i", unpriv_fault_o, i[0]);
         chk("mem_type", mem_type_o, MT[i]);
         chk("attr_byte", attr_byte_o, EFF[i]);
         chk("aux_byte", aux_byte_o, 8'(64'h8765_4321_0000_0000 >> (8 * i)));
      end
      $display("lookup test done");
      dec(32'h0006_352c, 4'h1, 5'b00001, 52'h0, 16'h0100, 8'h00);
      dec(32'h0006_3520, 4'h5, 5'b11001, B64, 16'h0100, 8'h00);
      dec(32'h0005_0528, 4'h2, 5'b11111, 52'hf_edcb_a987_6530, 16'h0100, 8'h00);
      dec(32'h0006_3728, 4'h0, 5'b11101, B64, 16'h0007, 8'h00);
      dec(32'h0006_3708, 4'h0, 5'b11100, B64, 16'h0000, 8'h00);
      dec(32'h0006_3538, 4'h0, 5'b11100, B64, 16'h0100, 8'h11);
      dec(32'h0006_3578, 4'h3, 5'b11101, B64, 16'h0100, 8'h00);
      dec(32'h0005_0d2b, 4'h4, 5'b11101, 52'hf_edcb_a987_6530, 16'h0100, 8'h00);
      apb(1'b1, REG_LIM_NS, 32'h0010_00ff);
      dec(32'h0006_352a, 4'h0, 5'b00001, 52'h0, 16'h0000, 8'h00);
      chk("part_unk", partition_id_unknown_o, 1'b1);
      apb(1'b0, REG_STATUS, 32'h0);
      chk("status", q, 32'h0000_000e);
      final_report();
   end
endmodule
bind cdud_top cdud_monitor u_mon (.mclk_i, .reset_n_i, .desc_valid_i, .lookup_valid_i,
   .attr_index_i, .lookup_done_o, .unpriv_fault_o, .second_hier_attr_disable_o,
   .second_table_base_o, .hw_use_sel_o, .aux_attr_low_o, .aux_attr_high_o, .aux_byte_o,
   .partition_id_o, .partition_id_unknown_o, .desc_loaded_o);
`default_nettype wire
